// ---- rtl/psm_host_pkg.sv ----
// Package with timing constants, widths and operation and refresh-mode types for the pseudo-static memory host controller.
package psm_host_pkg;

    // ------------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS      = 8;
    localparam int unsigned AUTO_REFRESH_NS    = 180;
    localparam int unsigned SELF_REFRESH_NS    = 8000;
    localparam int unsigned POWER_WAIT_NS      = 100000;
    localparam int unsigned REFRESH_PERIOD_NS  = 8000000;
    // Least times round up; the extra cycle makes "more than" strict.
    localparam int unsigned AUTO_REFRESH_CYC   = (AUTO_REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned SELF_REFRESH_CYC   = (SELF_REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned POWER_WAIT_CYC     = (POWER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned ROW_COUNT          = 512;
    // Longest time per row rounds down so all rows finish inside the window.
    localparam int unsigned ROW_INTERVAL_CYC   = REFRESH_PERIOD_NS / CLK_PERIOD_NS / ROW_COUNT;
    localparam int unsigned DUMMY_CYCLES       = 9;
    localparam int unsigned STROBE_LOW_CYC     = 4;
    localparam int unsigned STROBE_HIGH_CYC    = 4;
    localparam int unsigned GATE_DELAY_CYC     = 1;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W             = 17;
    localparam int unsigned DATA_W             = 8;
    localparam int unsigned ROW_W              = 9;
    localparam int unsigned CNT_W              = 24;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ_STROBE,
        OP_READ_GATE,
        OP_WRITE
    } op_e;

    typedef enum logic [1:0] {
        RF_ADDRESS,
        RF_AUTO,
        RF_SELF
    } refresh_mode_e;

endpackage : psm_host_pkg

// ---- rtl/psm_cycle_if.sv ----
// Interface carrying one timed strobe request from the sequencer to the cycle timer.
interface psm_cycle_if;
    logic                 start;
    logic [23:0]          length;
    logic                 done;

    modport master (
        output start,
        output length,
        input  done
    );
    modport timer (
        input  start,
        input  length,
        output done
    );
endinterface : psm_cycle_if

// ---- rtl/psm_cycle_timer.sv ----
// Down counter that times one phase of a memory cycle.
module psm_cycle_timer (
    input  wire logic     i_clk,
    input  wire logic     i_rst_n,
    psm_cycle_if.timer    cyc
);

    typedef struct packed {
        logic [23:0] count;
        logic        busy;
    } timer_s;

    timer_s state_q;
    timer_s state_d;

    // Load on start, count down, flag done on the last cycle.
    always_comb begin
        state_d = state_q;
        if (cyc.start) begin
            state_d.count = cyc.length;
            state_d.busy  = 1'b1;
        end else if (state_q.busy) begin
            if (state_q.count <= 24'h00_0001) begin
                state_d.busy = 1'b0;
            end
            state_d.count = state_q.count - 24'h00_0001;
        end
    end

    assign cyc.done = state_q.busy && (state_q.count <= 24'h00_0001);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : psm_cycle_timer

// ---- rtl/psm_host.sv ----
// Host controller that drives a byte-wide pseudo-static memory through its strobe pins.
//
// Summary of operation
// - Select high at strobe fall for accesses.
// - Address refresh: rows 0-511 within 8 ms.
// - Refresh request low over 180 ns; in self refresh it rises when i_sleep falls, even after one cycle.
// - Wait 100 us, then over eight dummies.
module psm_host #(
    parameter int unsigned POWER_WAIT_CYC   = psm_host_pkg::POWER_WAIT_CYC,
    parameter int unsigned ROW_INTERVAL_CYC = psm_host_pkg::ROW_INTERVAL_CYC,
    parameter int unsigned SELF_REFRESH_CYC = psm_host_pkg::SELF_REFRESH_CYC
) (
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_rst_n,
    // User side.
    input  wire logic                              i_req_valid,
    output      logic                              o_req_ready,
    input  wire logic [1:0]                        i_req_op,
    input  wire logic [psm_host_pkg::ADDR_W-1:0]   i_req_addr,
    input  wire logic [psm_host_pkg::DATA_W-1:0]   i_req_wdata,
    input  wire logic                              i_req_standby,
    output      logic                              o_rsp_valid,
    output      logic [psm_host_pkg::DATA_W-1:0]   o_rsp_rdata,
    input  wire logic [1:0]                        i_refresh_mode,
    input  wire logic                              i_sleep,
    output      logic                              o_init_done,
    output      logic                              o_self_refresh,
    // Memory side.
    output      logic                              o_access_strobe_n,
    output      logic                              o_output_gate_n,
    output      logic                              o_write_strobe_n,
    output      logic                              o_standby_select,
    output      logic                              o_refresh_request_n,
    output      logic [psm_host_pkg::ADDR_W-1:0]   o_addr,
    input  wire logic [psm_host_pkg::DATA_W-1:0]   i_data,
    output      logic [psm_host_pkg::DATA_W-1:0]   o_data,
    output      logic                              o_data_oe
);

    // ------------------------------------------------------------------
    // Reset release and types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_POWER_WAIT,
        ST_DUMMY_LOW,
        ST_DUMMY_HIGH,
        ST_IDLE,
        ST_ACC_LOW,
        ST_ACC_HIGH,
        ST_AUTO_LOW,
        ST_AUTO_HIGH,
        ST_SELF
    } state_e;

    typedef struct packed {
        state_e                            st;
        logic [psm_host_pkg::CNT_W-1:0]    wait_cnt;
        logic [psm_host_pkg::CNT_W-1:0]    row_tmr;
        logic [psm_host_pkg::ROW_W-1:0]    row;
        logic [3:0]                        dummies;
        logic                              refresh_due;
        logic                              is_refresh;
        logic [1:0]                        op;
        logic                              standby;
        logic                              strobe_n;
        logic                              gate_n;
        logic                              wstrobe_n;
        logic                              select;
        logic                              refresh_request_n_n;
        logic [psm_host_pkg::ADDR_W-1:0]   addr;
        logic [psm_host_pkg::DATA_W-1:0]   wdata;
        logic                              data_oe;
        logic                              rsp_valid;
        logic [psm_host_pkg::DATA_W-1:0]   rdata;
        logic                              init_done;
    } host_s;

    logic   rst_meta_q;
    logic   rst_sync_q;
    host_s  s_q;
    host_s  s_d;
    logic   tmr_done;

    psm_cycle_if cyc ();

    // Two flops release the reset synchronously to the clock.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    psm_cycle_timer u_timer (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_sync_q),
        .cyc     (cyc)
    );

    assign tmr_done = cyc.done;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Strobe phases are timed by the shared timer; the long waits use wait_cnt.
    always_comb begin
        s_d           = s_q;
        s_d.rsp_valid = 1'b0;
        cyc.start     = 1'b0;
        cyc.length    = 24'(psm_host_pkg::STROBE_LOW_CYC);
        unique case (s_q.st)
            ST_POWER_WAIT: begin
                if (s_q.wait_cnt == psm_host_pkg::CNT_W'(POWER_WAIT_CYC)) begin
                    s_d.st = ST_DUMMY_LOW;
                    cyc.start = 1'b1;
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt + 24'h00_0001;
                end
            end
            ST_DUMMY_LOW: begin
                s_d.strobe_n = 1'b0;
                if (tmr_done) begin
                    s_d.strobe_n = 1'b1;
                    s_d.dummies  = s_q.dummies + 4'h1;
                    s_d.st       = ST_DUMMY_HIGH;
                    cyc.start    = 1'b1;
                    cyc.length   = 24'(psm_host_pkg::STROBE_HIGH_CYC);
                end
            end
            ST_DUMMY_HIGH: begin
                if (tmr_done) begin
                    if (s_q.dummies == 4'(psm_host_pkg::DUMMY_CYCLES)) begin
                        s_d.st        = ST_IDLE;
                        s_d.init_done = 1'b1;
                    end else begin
                        s_d.st    = ST_DUMMY_LOW;
                        cyc.start = 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                s_d.data_oe = 1'b0;
                s_d.select  = 1'b1;
                if (i_sleep && (i_refresh_mode == 2'(psm_host_pkg::RF_SELF))) begin
                    s_d.refresh_request_n_n   = 1'b0;
                    s_d.wait_cnt = '0;
                    s_d.st       = ST_SELF;
                end else if (s_q.refresh_due && (i_refresh_mode == 2'(psm_host_pkg::RF_ADDRESS))) begin
                    s_d.refresh_due = 1'b0;
                    s_d.is_refresh  = 1'b1;
                    s_d.standby     = 1'b0;
                    s_d.op          = 2'(psm_host_pkg::OP_READ_STROBE);
                    s_d.addr        = psm_host_pkg::ADDR_W'(s_q.row);
                    s_d.row         = s_q.row + 9'h001;
                    s_d.select      = 1'b1;
                    s_d.st          = ST_ACC_LOW;
                    cyc.start       = 1'b1;
                end else if (s_q.refresh_due) begin
                    s_d.refresh_due = 1'b0;
                    s_d.refresh_request_n_n      = 1'b0;
                    s_d.st          = ST_AUTO_LOW;
                    cyc.start       = 1'b1;
                    cyc.length      = 24'(psm_host_pkg::AUTO_REFRESH_CYC);
                end else if (i_req_valid) begin
                    s_d.is_refresh = 1'b0;
                    s_d.op         = i_req_op;
                    s_d.addr       = i_req_addr;
                    s_d.wdata      = i_req_wdata;
                    s_d.standby    = i_req_standby;
                    s_d.select     = !i_req_standby;
                    s_d.data_oe    = (i_req_op == 2'(psm_host_pkg::OP_WRITE));
                    s_d.st         = ST_ACC_LOW;
                    cyc.start      = 1'b1;
                end
            end
            ST_ACC_LOW: begin
                s_d.strobe_n = 1'b0;
                // Gate-timed reads open the output later than the strobe.
                s_d.gate_n = !(!s_q.standby && !s_q.is_refresh && s_q.op != 2'(psm_host_pkg::OP_WRITE) &&
                              (s_q.op == 2'(psm_host_pkg::OP_READ_STROBE) || !s_q.strobe_n));
                s_d.wstrobe_n = !(!s_q.standby && s_q.op == 2'(psm_host_pkg::OP_WRITE) && !s_q.strobe_n);
                if (tmr_done) begin
                    // Write strobe rises with the access strobe, committing the byte.
                    s_d.strobe_n  = 1'b1;
                    s_d.wstrobe_n = 1'b1;
                    s_d.gate_n    = 1'b1;
                    if (!s_q.standby && !s_q.is_refresh && s_q.op != 2'(psm_host_pkg::OP_WRITE)) begin
                        s_d.rdata = i_data;
                    end
                    s_d.rsp_valid = !s_q.is_refresh;
                    s_d.st        = ST_ACC_HIGH;
                    cyc.start     = 1'b1;
                    cyc.length    = 24'(psm_host_pkg::STROBE_HIGH_CYC);
                end
            end
            ST_ACC_HIGH: begin
                s_d.data_oe = 1'b0;
                if (tmr_done) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_AUTO_LOW: begin
                if (tmr_done) begin
                    s_d.refresh_request_n_n = 1'b1;
                    s_d.st     = ST_AUTO_HIGH;
                    cyc.start  = 1'b1;
                    cyc.length = 24'(psm_host_pkg::STROBE_HIGH_CYC);
                end
            end
            ST_AUTO_HIGH: begin
                if (tmr_done) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_SELF: begin
                if (s_q.wait_cnt != psm_host_pkg::CNT_W'(SELF_REFRESH_CYC)) begin
                    s_d.wait_cnt = s_q.wait_cnt + 24'h00_0001;
                end
                s_d.refresh_due = 1'b0;
                if (!i_sleep) begin
                    s_d.refresh_request_n_n = 1'b1;
                    s_d.st     = ST_AUTO_HIGH;
                    cyc.start  = 1'b1;
                    cyc.length = 24'(psm_host_pkg::STROBE_HIGH_CYC);
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Row timer paces distributed refresh so 512 rows fit in the period.
        // It sits after the state decode so a new tick wins over a clear in the same cycle.
        if (s_q.init_done && (s_q.row_tmr == '0)) begin
            s_d.row_tmr     = psm_host_pkg::CNT_W'(ROW_INTERVAL_CYC - 1);
            s_d.refresh_due = 1'b1;
        end else if (s_q.init_done) begin
            s_d.row_tmr = s_q.row_tmr - 24'h00_0001;
        end
    end

    // State register with a defined idle-pin value at reset.
    always_ff @(posedge i_clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_q           <= '0;
            s_q.st        <= ST_POWER_WAIT;
            s_q.strobe_n  <= 1'b1;
            s_q.gate_n    <= 1'b1;
            s_q.wstrobe_n <= 1'b1;
            s_q.refresh_request_n_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_req_ready         = (s_q.st == ST_IDLE) && !s_q.refresh_due && !i_sleep;
    assign o_rsp_valid         = s_q.rsp_valid;
    assign o_rsp_rdata         = s_q.rdata;
    assign o_init_done         = s_q.init_done;
    assign o_self_refresh      = (s_q.st == ST_SELF) && (s_q.wait_cnt == psm_host_pkg::CNT_W'(SELF_REFRESH_CYC));
    assign o_access_strobe_n   = s_q.strobe_n;
    assign o_output_gate_n     = s_q.gate_n;
    assign o_write_strobe_n    = s_q.wstrobe_n;
    assign o_standby_select    = s_q.select;
    assign o_refresh_request_n = s_q.refresh_request_n_n;
    assign o_addr              = s_q.addr;
    assign o_data              = s_q.wdata;
    assign o_data_oe           = s_q.data_oe;

endmodule : psm_host

// ---- verif/psm_host_properties.sv ----
// Concurrent checks on the host controller's strobe, gate, refresh-request and bus-enable pins and its ready and init-done outputs.
module psm_host_properties #(
    parameter int unsigned POWER_WAIT_CYC = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic o_req_ready,
    input wire logic o_init_done,
    input wire logic o_access_strobe_n,
    input wire logic o_output_gate_n,
    input wire logic o_write_strobe_n,
    input wire logic o_refresh_request_n,
    input wire logic o_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // -----------------------------------------
    // Helper counters
    // -----------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    logic [15:0] up_q;
    logic [7:0]  low_q;
    logic [7:0]  fall_q;

    // up_q and low_q saturate so a long sleep cannot wrap them into a false short pulse.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_q   <= '0;
            low_q  <= '0;
            fall_q <= '0;
        end else begin
            up_q   <= (&up_q) ? up_q : up_q + 16'h0001;
            low_q  <= o_refresh_request_n ? 8'h00 : ((&low_q) ? low_q : low_q + 8'h01);
            if ($fell(o_access_strobe_n) && !o_init_done)
                fall_q <= fall_q + 8'h01;
        end
    end

    // -----------------------------------------
    // Assertions
    // -----------------------------------------
    a_ready_init: assert property (!o_init_done |-> !o_req_ready)
        else $error("request taken before start-up ended");
    a_power_wait: assert property ($fell(o_access_strobe_n) && !o_init_done |-> up_q >= POWER_WAIT_CYC)
        else $error("dummy strobe before power wait ended");
    a_dummy_count: assert property ($rose(o_init_done) |-> fall_q >= psm_host_pkg::DUMMY_CYCLES)
        else $error("too few dummy strobes");
    a_request_at_fall: assert property ($fell(o_access_strobe_n) |-> o_refresh_request_n)
        else $error("refresh request low at strobe fall");
    a_request_idle: assert property ($fell(o_refresh_request_n) |-> o_access_strobe_n)
        else $error("refresh request fell with strobe low");
    a_request_len: assert property ($rose(o_refresh_request_n) |-> low_q >= 8'h17)
        else $error("refresh request pulse too short");
    a_write_inside: assert property (!o_write_strobe_n |-> !o_access_strobe_n && o_data_oe)
        else $error("write strobe outside access or bus not driven");
    a_gate_inside: assert property (!o_output_gate_n |-> !o_access_strobe_n && o_write_strobe_n)
        else $error("output gate outside a read");

    c_init: cover property ($rose(o_init_done));
    c_refresh: cover property ($fell(o_refresh_request_n));
    c_write: cover property ($fell(o_write_strobe_n));
endmodule // psm_host_properties

bind psm_host psm_host_properties #(.POWER_WAIT_CYC(POWER_WAIT_CYC)) u_props (
    .i_clk_sys, .i_rst_n, .o_req_ready, .o_init_done, .o_access_strobe_n,
    .o_output_gate_n, .o_write_strobe_n, .o_refresh_request_n, .o_data_oe
);

// ---- verif/psm_device_model.sv ----
// Behavioural model of the byte-wide pseudo-static memory, driven by its pins.
module psm_device_model (
    input  wire logic        i_access_strobe_n,
    input  wire logic        i_output_gate_n,
    input  wire logic        i_write_strobe_n,
    input  wire logic        i_standby_select,
    input  wire logic        i_refresh_request_n,
    input  wire logic [16:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output      logic [7:0]  o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]   mem [131072];
    logic [16:0]  lat_q = '0;
    logic         act = 1'b0;
    logic         wr_low = 1'b0;
    logic [7:0]   last = 8'h00;
    logic [511:0] rows_seen = '0;
    logic [8:0]   row_ctr = '0;
    logic         self_on = 1'b0;
    int           n_fall = 0;
    int           n_standby = 0;
    int           n_auto = 0;
    int           n_bad = 0;
    realtime      t_low = 0.0;

    // Cells start cleared so an unwritten address reads as zero.
    initial foreach (mem[i]) mem[i] = 8'h00;

    // Whole address and select are taken at the strobe fall.
    always @(negedge i_access_strobe_n) begin
        n_fall++;
        act = i_standby_select;
        lat_q = i_addr;
        if (!i_refresh_request_n)
            n_bad++;
        if (act)
            rows_seen[i_addr[8:0]] = 1'b1;
        else
            n_standby++;
    end

    // A write is committed once, at the first rising strobe.
    always @(negedge i_write_strobe_n) wr_low = act;
    always @(posedge i_write_strobe_n or posedge i_access_strobe_n) begin
        if (wr_low)
            mem[lat_q] = i_wdata;
        wr_low = 1'b0;
        if (i_access_strobe_n)
            act = 1'b0;
    end

    // A released bus shows the inverse of the last byte, never a stale copy.
    always @* begin
        if (act && !i_access_strobe_n && !i_output_gate_n && i_write_strobe_n) begin
            last = mem[lat_q];
            o_rdata = last;
        end else
            o_rdata = ~last;
    end

    // Request length picks auto or self refresh; address pins are not looked at.
    always @(negedge i_refresh_request_n) if (i_access_strobe_n) t_low = $realtime;
    always @(posedge i_refresh_request_n) begin
        if ($realtime - t_low > 8000.0)
            self_on = 1'b1;
        else if ($realtime - t_low > 180.0) begin
            n_auto++;
            row_ctr = row_ctr + 9'h001;
        end
    end
endmodule // psm_device_model

// ---- verif/psm_host_test.sv ----
// Self-checking bench for the pseudo-static memory host controller.
module psm_host_test;
    timeunit 1ns;
    timeprecision 1ps;

    // -----------------------------------------
    // Stimulus, design and memory
    // -----------------------------------------
    typedef struct packed {
        logic [1:0]  op;
        logic [16:0] a;
        logic [7:0]  d;
        logic        sb;
    } row_s;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        valid = 1'b0;
    logic [1:0]  op = 2'h0;
    logic [16:0] addr = '0;
    logic [7:0]  wd = 8'h00;
    logic        sb = 1'b0;
    logic [1:0]  mode = 2'h1;
    logic        sleep = 1'b0;
    logic        ready, rsp_v, init_done, self_ref, as_n, og_n, ws_n, ss, rr_n, oe;
    logic [7:0]  rdata, dout, mdat, bus;
    logic [16:0] paddr;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    row_s        rows [8] = '{
        '{2'h2, 17'h1_2345, 8'ha5, 1'h0}, '{2'h0, 17'h1_2345, 8'ha5, 1'h0},
        '{2'h2, 17'h0_0000, 8'h3c, 1'h0}, '{2'h1, 17'h0_0000, 8'h3c, 1'h0},
        '{2'h2, 17'h1_ffff, 8'h5a, 1'h0}, '{2'h0, 17'h1_ffff, 8'h5a, 1'h0},
        '{2'h2, 17'h1_2345, 8'hff, 1'h1}, '{2'h1, 17'h1_2345, 8'ha5, 1'h0}};

    // Clock; the data wire is resolved from both drivers.
    always #4 clk = ~clk;
    assign bus = oe ? dout : mdat;

    psm_host #(.POWER_WAIT_CYC(20), .ROW_INTERVAL_CYC(50), .SELF_REFRESH_CYC(10)) uut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_req_valid(valid), .o_req_ready(ready),
        .i_req_op(op), .i_req_addr(addr), .i_req_wdata(wd), .i_req_standby(sb),
        .o_rsp_valid(rsp_v), .o_rsp_rdata(rdata), .i_refresh_mode(mode), .i_sleep(sleep),
        .o_init_done(init_done), .o_self_refresh(self_ref), .o_access_strobe_n(as_n),
        .o_output_gate_n(og_n), .o_write_strobe_n(ws_n), .o_standby_select(ss),
        .o_refresh_request_n(rr_n), .o_addr(paddr), .i_data(bus), .o_data(dout), .o_data_oe(oe));

    psm_device_model model (
        .i_access_strobe_n(as_n), .i_output_gate_n(og_n), .i_write_strobe_n(ws_n),
        .i_standby_select(ss), .i_refresh_request_n(rr_n), .i_addr(paddr),
        .i_wdata(bus), .o_rdata(mdat));

    // -----------------------------------------
    // Tasks
    // -----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Holds the request until the edge that takes it, then waits for the answer.
    task automatic req(input row_s r);
        int n;
        tick(1);
        valid = 1'b1;
        op = r.op;
        addr = r.a;
        wd = r.d;
        sb = r.sb;
        n = 0;
        do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 300);
        tick(1);
        valid = 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while (rsp_v !== 1'b1 && n < 50);
        chk(n < 50, 1);
    endtask

    task automatic close_out();
        $display("Counts: checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // A hung handshake ends the run as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            close_out();
        end
    end

    // -----------------------------------------
    // Main sequence
    // -----------------------------------------
    initial begin
        int n;
        tick(5);
        chk({as_n, og_n, ws_n, rr_n, ss, oe, ready}, 7'h78);
        tick(3);
        rst_n = 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (init_done !== 1'b1 && n < 1000);
        chk(init_done, 1);
        chk(model.n_fall > 8, 1);
        // Dummy strobes run with select low, so standby counting starts here.
        model.n_standby = 0;
        $display("Test reset and start-up done");
        for (int i = 0; i < 8; i++) begin
            req(rows[i]);
            if (rows[i].op != 2'h2)
                chk(rdata, rows[i].d);
        end
        chk(model.n_standby, 1);
        tick(200);
        chk(model.n_auto > 0, 1);
        chk(model.n_bad, 0);
        $display("Test access table and auto refresh done");
        mode = 2'h2;
        sleep = 1'b1;
        tick(1100);
        chk(self_ref, 1);
        sleep = 1'b0;
        tick(50);
        chk(model.self_on, 1);
        chk(self_ref, 0);
        $display("Test self refresh done");
        mode = 2'h0;
        model.rows_seen = '0;
        tick(512 * 60);
        chk(&model.rows_seen, 1);
        req(rows[1]);
        chk(rdata, 8'ha5);
        $display("Test address refresh done");
        close_out();
    end
endmodule // psm_host_test
